// ===== hdl/rx_lane_status_fc.sv
// receive lane status, diagnostic word checks and in-band flow-control extraction
// What this block does
// - per lane, hold last diagnostic CRC32 validity
// - pulse lane CRC32 fail bit one cycle
// - fill calendar from control word bits 55-40
// - calendar bit one is XON, zero XOFF
// - keep only 256 entries, drop the rest
// - short calendar leaves untouched bits unchanged
// - first received entry lands in bit zero
// - CRC24 error or alignment loss clears calendar
// - calendar output changes only on user clock
// - multi-use output is control word bits 31:24
// - pulse update flag one cycle per update
// - word lock after 64 good framing patterns
// - word lock ignores sync and scrambler words
// - synced needs lock, sync and scrambler words
// - flag CRC24 mismatch on received control word
// - expose diagnostic bits 33 and 32 per lane
//
// The APB register port and the placing of the registers were decided locally.
module rx_lane_status_fc #(
	parameter int LANES = rx_lane_status_pkg::NUM_LANES
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	output logic                    irq,
	// per-lane receive words
	input  wire logic [LANES-1:0]   lane_word_valid,
	input  wire logic [2*LANES-1:0] lane_framing,
	input  wire logic [LANES-1:0]   lane_mf_sync_ok,
	input  wire logic [LANES-1:0]   lane_scrambler_ok,
	// per-lane diagnostic words
	input  wire logic [LANES-1:0]   diag_word_valid,
	input  wire logic [LANES-1:0]   diag_crc_match,
	input  wire logic [LANES-1:0]   diag_bit33,
	input  wire logic [LANES-1:0]   diag_bit32,
	// received control words
	input  wire logic               ctrl_word_valid,
	input  wire logic [63:0]        ctrl_word,
	input  wire logic [23:0]        ctrl_crc24_rx,
	input  wire logic [23:0]        ctrl_crc24_calc,
	input  wire logic               align_lost,
	// status outputs
	output logic [LANES-1:0]        word_lock,
	output logic [LANES-1:0]        synced,
	output logic [LANES-1:0]        diag_word_check_ok,
	output logic [LANES-1:0]        diag_word_check_fail_pulse,
	output logic [LANES-1:0]        lane_health,
	output logic [LANES-1:0]        intf_health,
	output logic [255:0]            rx_calendar_xon_vector,
	output logic [7:0]              multi_use,
	output logic                    multi_use_updated,
	output logic                    control_word_check_fail
);
	localparam int GW = $clog2(rx_lane_status_pkg::CAL_GROUPS) + 1;

	logic [LANES-1:0]                         lock_raw;
	logic                                     crc_bad;
	logic                                     cw_good;
	logic [GW-1:0]                            cal_group;
	logic [GW-1:0]                            group_sel;
	logic [rx_lane_status_pkg::CAL_GROUP-1:0] cal_bits;
	logic [rx_lane_status_pkg::IRQ_BITS-1:0]  irq_status;
	logic [rx_lane_status_pkg::IRQ_BITS-1:0]  irq_mask;
	logic [rx_lane_status_pkg::IRQ_BITS-1:0]  irq_events;
	logic [0:0]                               cal_enable;
	logic                                     apb_setup;
	logic                                     apb_write;

	// pick the register that a read returns
	function automatic logic [31:0] read_mux(input logic [7:0] addr);
		logic [31:0] d;
		d = 32'h0;
		unique case (addr)
			rx_lane_status_pkg::OFF_IRQ_STATUS: d = 32'(irq_status);
			rx_lane_status_pkg::OFF_IRQ_MASK:   d = 32'(irq_mask);
			rx_lane_status_pkg::OFF_LANE_STAT:
				d = 32'(word_lock) | (32'(synced) << rx_lane_status_pkg::SYNCED_LSB);
			rx_lane_status_pkg::OFF_DIAG_STAT:  d = 32'(diag_word_check_ok);
			rx_lane_status_pkg::OFF_MULTI_USE:  d = 32'(multi_use);
			rx_lane_status_pkg::OFF_CONTROL:    d = 32'(cal_enable);
			default:                            d = 32'h0;
		endcase
		return d;
	endfunction

	function automatic logic is_mapped(input logic [7:0] addr);
		return addr == rx_lane_status_pkg::OFF_IRQ_STATUS ||
			addr == rx_lane_status_pkg::OFF_IRQ_MASK ||
			addr == rx_lane_status_pkg::OFF_LANE_STAT ||
			addr == rx_lane_status_pkg::OFF_DIAG_STAT ||
			addr == rx_lane_status_pkg::OFF_MULTI_USE ||
			addr == rx_lane_status_pkg::OFF_CONTROL;
	endfunction

	// first entry arrives on the highest bit of the field
	function automatic logic [15:0] entry_order(input logic [63:0] cw);
		logic [15:0] r;
		r = 16'h0;
		for (int k = 0; k < rx_lane_status_pkg::CAL_GROUP; k++) begin
			r[k] = cw[rx_lane_status_pkg::CW_CAL_HI - k];
		end
		return r;
	endfunction

	// per-lane lock, sync and diagnostic word status
	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			word_lock_counter #(
				.LOCK_COUNT (rx_lane_status_pkg::LOCK_COUNT)
			) u_lock (
				.pclk       (pclk),
				.presetn    (presetn),
				.word_valid (lane_word_valid[gi]),
				.framing    (lane_framing[2*gi +: 2]),
				.locked     (lock_raw[gi])
			);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					word_lock[gi] <= 1'b0;
					synced[gi]    <= 1'b0;
				end else begin
					word_lock[gi] <= lock_raw[gi];
					synced[gi]    <= lock_raw[gi] & lane_mf_sync_ok[gi] &
						lane_scrambler_ok[gi];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					diag_word_check_ok[gi]         <= 1'b0;
					diag_word_check_fail_pulse[gi] <= 1'b0;
					lane_health[gi]                <= 1'b0;
					intf_health[gi]                <= 1'b0;
				end else begin
					diag_word_check_fail_pulse[gi] <= diag_word_valid[gi] &
						~diag_crc_match[gi];
					if (diag_word_valid[gi]) begin
						diag_word_check_ok[gi] <= diag_crc_match[gi];
						lane_health[gi]        <= diag_bit33[gi];
						intf_health[gi]        <= diag_bit32[gi];
					end
				end
			end
		end
	endgenerate

	// control word checks
	assign crc_bad = ctrl_word_valid && (ctrl_crc24_rx != ctrl_crc24_calc);
	assign cw_good = ctrl_word_valid && !crc_bad;
	assign group_sel = ctrl_word[rx_lane_status_pkg::CW_CAL_START] ? '0 : cal_group;
	assign cal_bits  = entry_order(ctrl_word);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_word_check_fail <= 1'b0;
		end else begin
			control_word_check_fail <= crc_bad;
		end
	end

	// calendar position tracking; saturates after the last group
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_group <= '0;
		end else if (crc_bad || align_lost) begin
			cal_group <= '0;
		end else if (cw_good && group_sel != GW'(rx_lane_status_pkg::CAL_GROUPS)) begin
			cal_group <= group_sel + GW'(1);
		end else if (cw_good) begin
			cal_group <= group_sel;
		end
	end

	// flow-control vector, updated only on pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_calendar_xon_vector <= '0;
		end else if (crc_bad || align_lost) begin
			rx_calendar_xon_vector <= '0;
		end else if (cw_good && cal_enable[0] &&
			group_sel != GW'(rx_lane_status_pkg::CAL_GROUPS)) begin
			// only the addressed group moves, the rest keep their state
			rx_calendar_xon_vector[group_sel[GW-2:0] * 16 +: 16] <= cal_bits;
		end
	end

	// multi-use field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			multi_use         <= 8'h00;
			multi_use_updated <= 1'b0;
		end else begin
			multi_use_updated <= cw_good;
			if (cw_good) begin
				multi_use <= ctrl_word[rx_lane_status_pkg::CW_MU_HI:rx_lane_status_pkg::CW_MU_LO];
			end
		end
	end

	// apb slave: read data latched in setup, one wait-free access cycle
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !is_mapped(paddr);
			prdata  <= (apb_setup && !pwrite) ? read_mux(paddr) : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask   <= rx_lane_status_pkg::IRQ_MASK_RST;
			cal_enable <= rx_lane_status_pkg::CONTROL_RST;
		end else if (apb_write) begin
			if (paddr == rx_lane_status_pkg::OFF_IRQ_MASK) begin
				irq_mask <= pwdata[rx_lane_status_pkg::IRQ_BITS-1:0];
			end
			if (paddr == rx_lane_status_pkg::OFF_CONTROL) begin
				cal_enable <= pwdata[0:0];
			end
		end
	end

	// sticky events, write one to clear; a new event wins over the clear
	assign irq_events[rx_lane_status_pkg::IRQ_CW_FAIL]    = control_word_check_fail;
	assign irq_events[rx_lane_status_pkg::IRQ_DIAG_FAIL]  = |diag_word_check_fail_pulse;
	assign irq_events[rx_lane_status_pkg::IRQ_MU_UPDATE]  = multi_use_updated;
	assign irq_events[rx_lane_status_pkg::IRQ_ALIGN_LOST] = align_lost;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else if (apb_write && paddr == rx_lane_status_pkg::OFF_IRQ_STATUS) begin
			irq_status <= (irq_status & ~pwdata[rx_lane_status_pkg::IRQ_BITS-1:0]) |
				irq_events;
		end else begin
			irq_status <= irq_status | irq_events;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence diag_bad_once;
		diag_word_valid[0] && !diag_crc_match[0] ##1 !diag_word_valid[0];
	endsequence

	sequence good_cal_start;
		cw_good && !align_lost && cal_enable[0] && ctrl_word[rx_lane_status_pkg::CW_CAL_START];
	endsequence

	chk_diag_fail_single: assert property (
		diag_bad_once |-> diag_word_check_fail_pulse[0] ##1 !diag_word_check_fail_pulse[0])
		else $error("diagnostic fail pulse not exactly one cycle");

	chk_diag_ok_tracks: assert property (
		diag_word_valid[0] |=> diag_word_check_ok[0] == $past(diag_crc_match[0]))
		else $error("diagnostic validity flag did not follow crc result");

	chk_vector_crc_clear: assert property (
		crc_bad |=> rx_calendar_xon_vector == '0)
		else $error("calendar not cleared after control word crc error");

	chk_vector_align_clear: assert property (
		align_lost |=> rx_calendar_xon_vector == '0)
		else $error("calendar not cleared after alignment loss");

	chk_first_entry_order: assert property (
		good_cal_start |=> rx_calendar_xon_vector[0] == $past(ctrl_word[55]) &&
			rx_calendar_xon_vector[15] == $past(ctrl_word[40]))
		else $error("first calendar entries not in arrival order");

	chk_cal_discard: assert property (
		cw_good && !align_lost && !ctrl_word[rx_lane_status_pkg::CW_CAL_START] &&
		cal_group == GW'(rx_lane_status_pkg::CAL_GROUPS)
		|=> $stable(rx_calendar_xon_vector))
		else $error("calendar changed by entry beyond the last");

	chk_mu_update_pulse: assert property (
		cw_good ##1 !ctrl_word_valid |-> multi_use_updated &&
			multi_use == $past(ctrl_word[31:24]) ##1 !multi_use_updated)
		else $error("multi-use update not a single cycle with new value");

	chk_synced_needs_lock: assert property (
		synced[4] |-> $past(lock_raw[4]) && $past(lane_mf_sync_ok[4]) &&
			$past(lane_scrambler_ok[4]))
		else $error("lane synced without lock, sync and scrambler words");

	chk_lock_sync_free: assert property (
		lock_raw[0] |=> word_lock[0])
		else $error("word lock held back by sync or scrambler state");

	chk_fail_pulse_cause: assert property (
		diag_word_check_fail_pulse[0] |-> $past(diag_word_valid[0]) && !$past(diag_crc_match[0]))
		else $error("diagnostic fail pulse without a bad diagnostic word");

	chk_health_latch: assert property (
		diag_word_valid[0] |=> lane_health[0] == $past(diag_bit33[0]) &&
			intf_health[0] == $past(diag_bit32[0]))
		else $error("health bits did not follow diagnostic word");

	chk_cw_fail_cause: assert property (
		control_word_check_fail |-> $past(ctrl_word_valid) &&
			$past(ctrl_crc24_rx) != $past(ctrl_crc24_calc))
		else $error("crc24 fail raised without a mismatching control word");

	chk_mu_hold: assert property (
		!cw_good |=> $stable(multi_use))
		else $error("multi-use field changed without a good control word");

	chk_vector_gated: assert property (
		cw_good && !cal_enable[0] && !align_lost |=> $stable(rx_calendar_xon_vector))
		else $error("calendar moved while updates disabled");

	chk_pready_one_cycle: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("bus ready not a single cycle after setup");

	chk_irq_follows: assert property (
		irq_status[rx_lane_status_pkg::IRQ_CW_FAIL] && irq_mask[rx_lane_status_pkg::IRQ_CW_FAIL]
		|=> irq)
		else $error("interrupt not raised for unmasked status");
endmodule

// ===== shared/rx_lane_status_pkg.sv
// constants for the receive lane status and in-band flow-control block
package rx_lane_status_pkg;
	localparam int          NUM_LANES      = 12;
	localparam int          CAL_ENTRIES    = 256;
	localparam int          CAL_GROUP      = 16;
	localparam int          CAL_GROUPS     = CAL_ENTRIES / CAL_GROUP;
	localparam int          LOCK_COUNT     = 64;
	// control word field positions
	localparam int          CW_CAL_HI      = 55;
	localparam int          CW_CAL_LO      = 40;
	localparam int          CW_CAL_START   = 56;
	localparam int          CW_MU_HI       = 31;
	localparam int          CW_MU_LO       = 24;
	// framing patterns on bits[65:64]
	localparam logic [1:0]  FRAME_DATA     = 2'h1;
	localparam logic [1:0]  FRAME_CTRL     = 2'h2;
	// register byte offsets
	localparam logic [7:0]  OFF_IRQ_STATUS = 8'h00;
	localparam logic [7:0]  OFF_IRQ_MASK   = 8'h04;
	localparam logic [7:0]  OFF_LANE_STAT  = 8'h08;
	localparam logic [7:0]  OFF_DIAG_STAT  = 8'h0C;
	localparam logic [7:0]  OFF_MULTI_USE  = 8'h10;
	localparam logic [7:0]  OFF_CONTROL    = 8'h14;
	// interrupt status bit positions
	localparam int          IRQ_CW_FAIL    = 0;
	localparam int          IRQ_DIAG_FAIL  = 1;
	localparam int          IRQ_MU_UPDATE  = 2;
	localparam int          IRQ_ALIGN_LOST = 3;
	localparam int          IRQ_BITS       = 4;
	// reset values and the lane status synced field position
	localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;
	localparam logic [0:0]  CONTROL_RST    = 1'h1;
	localparam int          SYNCED_LSB     = 16;
endpackage

// ===== hdl/word_lock_counter.sv
// per-lane 64b/67b word boundary lock from consecutive framing patterns
module word_lock_counter #(
	parameter int LOCK_COUNT = rx_lane_status_pkg::LOCK_COUNT
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       word_valid,
	input  wire logic [1:0] framing,
	output logic            locked
);
	logic [6:0] run_count;
	logic       frame_good;

	assign frame_good = (framing == rx_lane_status_pkg::FRAME_DATA) ||
		(framing == rx_lane_status_pkg::FRAME_CTRL);

	// only the framing check counts; sync and scrambler words play no part
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_count <= 7'h00;
			locked    <= 1'b0;
		end else if (word_valid) begin
			if (!frame_good) begin
				run_count <= 7'h00;
				locked    <= 1'b0;
			end else if (run_count == 7'(LOCK_COUNT - 1)) begin
				locked    <= 1'b1;
			end else begin
				run_count <= run_count + 7'h01;
			end
		end
	end

	chk_lock_after_run: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(locked) |-> $past(run_count) == 7'(LOCK_COUNT - 1))
		else $error("lock set before full run of good framing");
endmodule

// ===== verif/remote_tx_model.sv
// behavioural far-end transmitter: lane words, diagnostic words, control words
module remote_tx_model (
	input  wire logic pclk,
	output logic [11:0] lane_word_valid,
	output logic [23:0] lane_framing,
	output logic [11:0] lane_mf_sync_ok,
	output logic [11:0] lane_scrambler_ok,
	output logic [11:0] diag_word_valid,
	output logic [11:0] diag_crc_match,
	output logic [11:0] diag_bit33,
	output logic [11:0] diag_bit32,
	output logic        ctrl_word_valid,
	output logic [63:0] ctrl_word,
	output logic [23:0] ctrl_crc24_rx,
	output logic [23:0] ctrl_crc24_calc,
	output logic        align_lost
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{lane_word_valid, lane_framing, diag_word_valid, diag_crc_match} = '0;
		{diag_bit33, diag_bit32, ctrl_word_valid, ctrl_word, align_lost} = '0;
		{ctrl_crc24_rx, ctrl_crc24_calc} = '0;
		// lanes 4-7 get both sync and scrambler words, 0-3 scrambler only
		lane_mf_sync_ok = 12'h0F0;
		lane_scrambler_ok = 12'h0FF;
	end
	// the released control word shows the inverse so stale data cannot match; crc fields hold
	task automatic send_ctrl(input logic sop, input logic [15:0] cal, input logic [7:0] mu,
			input logic good);
		@(posedge pclk);
		ctrl_word <= {7'h00, sop, cal, 8'h00, mu, 24'h5A5A5A};
		ctrl_crc24_rx <= 24'h3C3C3C;
		ctrl_crc24_calc <= good ? 24'h3C3C3C : 24'hC3C3C3;
		ctrl_word_valid <= 1'b1;
		@(posedge pclk);
		ctrl_word_valid <= 1'b0;
		ctrl_word <= ~ctrl_word;
	endtask
	task automatic lose_align();
		@(posedge pclk);
		align_lost <= 1'b1;
		@(posedge pclk);
		align_lost <= 1'b0;
	endtask
	task automatic send_words(input int n, input logic [11:0] bad);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			lane_word_valid <= 12'hFFF;
			for (int l = 0; l < 12; l++) lane_framing[2*l+:2] <= bad[l] ? 2'h0 : (i[0] ? 2'h2 : 2'h1);
		end
		@(posedge pclk);
		lane_word_valid <= 12'h000;
		lane_framing <= ~lane_framing;
	endtask
	task automatic send_diag(input logic [11:0] ok, input logic [11:0] b33, input logic [11:0] b32);
		@(posedge pclk);
		diag_word_valid <= 12'hFFF;
		diag_crc_match <= ok;
		diag_bit33 <= b33;
		diag_bit32 <= b32;
		@(posedge pclk);
		diag_word_valid <= 12'h000;
		diag_crc_match <= ~ok;
	endtask
endmodule

// ===== verif/interlaken_rx_lane_status_fc_bench.sv
// self-checking bench for the receive lane status and flow-control block
module interlaken_rx_lane_status_fc_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic sop; logic [15:0] cal; logic [7:0] mu; logic good;} cw_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [11:0] lane_word_valid, lane_mf_sync_ok, lane_scrambler_ok, diag_word_valid;
	logic [11:0] diag_crc_match, diag_bit33, diag_bit32, word_lock, synced, lane_health;
	logic [11:0] diag_word_check_ok, diag_word_check_fail_pulse, intf_health;
	logic [23:0] lane_framing, ctrl_crc24_rx, ctrl_crc24_calc;
	logic ctrl_word_valid, align_lost, multi_use_updated, control_word_check_fail, err;
	logic [63:0] ctrl_word;
	logic [255:0] rx_calendar_xon_vector, exp_vec = '0;
	logic [7:0] multi_use, exp_mu = 8'h00;
	int failures = 0, cmp_count = 0, grp = 16;
	cw_row_t rows [6] = '{'{1, 16'h8001, 8'hA1, 1}, '{0, 16'h00FF, 8'hB2, 1},
		'{0, 16'hF0F0, 8'hC3, 1}, '{1, 16'h1234, 8'hD4, 1}, '{0, 16'hFFFF, 8'hE5, 0},
		'{1, 16'hC001, 8'h96, 1}};
	always #2 pclk = ~pclk;
	rx_lane_status_fc dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .lane_word_valid(lane_word_valid), .lane_framing(lane_framing),
		.lane_mf_sync_ok(lane_mf_sync_ok), .lane_scrambler_ok(lane_scrambler_ok),
		.diag_word_valid(diag_word_valid), .diag_crc_match(diag_crc_match),
		.diag_bit33(diag_bit33), .diag_bit32(diag_bit32), .ctrl_word_valid(ctrl_word_valid),
		.ctrl_word(ctrl_word), .ctrl_crc24_rx(ctrl_crc24_rx), .ctrl_crc24_calc(ctrl_crc24_calc),
		.align_lost(align_lost), .word_lock(word_lock), .synced(synced),
		.diag_word_check_ok(diag_word_check_ok),
		.diag_word_check_fail_pulse(diag_word_check_fail_pulse), .lane_health(lane_health),
		.intf_health(intf_health), .rx_calendar_xon_vector(rx_calendar_xon_vector),
		.multi_use(multi_use), .multi_use_updated(multi_use_updated),
		.control_word_check_fail(control_word_check_fail)
	);
	remote_tx_model tx (
		.pclk(pclk), .lane_word_valid(lane_word_valid), .lane_framing(lane_framing),
		.lane_mf_sync_ok(lane_mf_sync_ok), .lane_scrambler_ok(lane_scrambler_ok),
		.diag_word_valid(diag_word_valid), .diag_crc_match(diag_crc_match),
		.diag_bit33(diag_bit33), .diag_bit32(diag_bit32), .ctrl_word_valid(ctrl_word_valid),
		.ctrl_word(ctrl_word), .ctrl_crc24_rx(ctrl_crc24_rx), .ctrl_crc24_calc(ctrl_crc24_calc),
		.align_lost(align_lost)
	);
	task automatic check(input logic [255:0] seen, input logic [255:0] want, input string what);
		cmp_count++;
		if (seen !== want) begin
			failures++;
			$display("[ERR] %0t %s: seen %0h want %0h", $time, what, seen, want);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			end_of_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// calendar model: sop restarts at group 0, 16 groups at most, bad crc clears and restarts
	task automatic cw_step(input cw_row_t r);
		tx.send_ctrl(r.sop, r.cal, r.mu, r.good);
		if (!r.good) begin
			exp_vec = '0;
			grp = 0;
		end else begin
			if (r.sop) grp = 0;
			if (grp < 16) for (int k = 0; k < 16; k++) exp_vec[16*grp+k] = r.cal[15-k];
			if (grp < 16) grp++;
			exp_mu = r.mu;
		end
		#1;
		check(rx_calendar_xon_vector, exp_vec, "calendar");
		check(multi_use, exp_mu, "multi use");
		check(multi_use_updated, r.good, "update pulse");
		check(control_word_check_fail, !r.good, "crc24 fail");
	endtask
	initial begin
		repeat (50000) @(posedge pclk);
		failures++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		check(rx_calendar_xon_vector, 0, "reset vector");
		check({word_lock, synced, diag_word_check_ok, multi_use, irq}, 0,
			"reset outputs");
		apb(0, rx_lane_status_pkg::OFF_IRQ_MASK, 0);
		check(rd, 0, "mask reset");
		apb(0, rx_lane_status_pkg::OFF_CONTROL, 0);
		check(rd, 1, "control reset");
		foreach (rows[i]) cw_step(rows[i]);
		for (int g = 0; g < 17; g++) cw_step('{g == 0, 16'(g * 16'h1357 + 1), 8'(g), 1'b1});
		@(posedge pclk);
		#1;
		check(multi_use_updated, 0, "update pulse width");
		tx.lose_align();
		#1;
		check(rx_calendar_xon_vector, 0, "align loss clears");
		tx.send_words(63, 12'h000);
		repeat (3) @(posedge pclk);
		#1;
		check(word_lock, 0, "63 words no lock");
		tx.send_words(1, 12'h000);
		@(posedge pclk);
		#1;
		check(word_lock, 12'hFFF, "lock on 64th");
		@(posedge pclk);
		#1;
		check(synced, 12'h0F0, "synced needs all");
		tx.send_words(1, 12'h020);
		repeat (3) @(posedge pclk);
		#1;
		check({synced, word_lock}, {12'h0D0, 12'hFDF}, "bad framing drops lock");
		tx.send_diag(12'hA5A, 12'h0F3, 12'h3C5);
		#1;
		check(diag_word_check_ok, 12'hA5A, "diag valid");
		check(diag_word_check_fail_pulse, 12'h5A5, "diag fail");
		check({lane_health, intf_health}, {12'h0F3, 12'h3C5}, "health bits");
		@(posedge pclk);
		#1;
		check(diag_word_check_fail_pulse, 0, "diag fail width");
		apb(0, rx_lane_status_pkg::OFF_LANE_STAT, 0);
		check(rd, 32'h00D00FDF, "lane stat");
		apb(0, rx_lane_status_pkg::OFF_DIAG_STAT, 0);
		check(rd, 32'h00000A5A, "diag stat");
		apb(0, rx_lane_status_pkg::OFF_MULTI_USE, 0);
		check(rd, 32'(exp_mu), "multi use reg");
		apb(0, 8'h20, 0);
		check({err, rd}, {1'b1, 32'h0}, "unmapped");
		apb(0, rx_lane_status_pkg::OFF_IRQ_STATUS, 0);
		check({irq, rd}, {1'b0, 32'hF}, "status all set");
		apb(1, rx_lane_status_pkg::OFF_IRQ_MASK, 1);
		repeat (2) @(posedge pclk);
		#1;
		check(irq, 1, "irq unmasked");
		apb(1, rx_lane_status_pkg::OFF_IRQ_STATUS, 1);
		repeat (2) @(posedge pclk);
		#1;
		check(irq, 0, "irq cleared");
		apb(0, rx_lane_status_pkg::OFF_IRQ_STATUS, 0);
		check(rd, 32'hE, "w1c one bit");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		check(rx_calendar_xon_vector, 0, "second reset vector");
		check({word_lock, diag_word_check_ok, multi_use, multi_use_updated}, 0,
			"second reset");
		presetn <= 1'b1;
		exp_vec = '0;
		exp_mu = 8'h00;
		@(posedge pclk);
		#1;
		check({synced, diag_word_check_fail_pulse, control_word_check_fail, irq}, 0,
			"after release");
		cw_step(rows[0]);
		apb(1, rx_lane_status_pkg::OFF_CONTROL, 0);
		tx.send_ctrl(1'b1, 16'h0F0F, 8'h5C, 1'b1);
		#1;
		check(rx_calendar_xon_vector, exp_vec, "calendar gated off");
		check(multi_use, 8'h5C, "multi use while gated");
		end_of_test();
	end
endmodule
